// File: core/abss_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Shared constants for the beacon burst slot scheduler.
// Assumes: 100 MHz clock, one TDMA frame of 2250 slots per UTC minute.
// Notes:   Offsets are byte addresses on the plain register port.
//------------------------------------------------------------------------------
package abss_pkg;

  // ----------------------------------------------------------------------------
  // Clock and frame timing
  // ----------------------------------------------------------------------------
  localparam longint CLK_HZ          = 64'd100000000;  // System clock rate.
  localparam longint FRAME_S         = 64'd60;         // One frame is one UTC minute.
  localparam int     SLOTS_PER_FRAME = 2250;           // Slots in a frame.
  // Slot length in cycles, times three, so the 26.67 ms slot stays exact.
  localparam longint SLOT_CYC_X3_L   = (64'd3 * FRAME_S * CLK_HZ) / 64'd2250;
  localparam int unsigned SLOT_CYC_X3 = 32'(SLOT_CYC_X3_L);
  localparam int     FIRST_MSG_S     = 60;             // Latest first message after start.

  // ----------------------------------------------------------------------------
  // Schedule constants, in slots
  // ----------------------------------------------------------------------------
  localparam logic [11:0] FRAME_SLOTS  = 12'h8CA;  // 2250 slots.
  localparam logic [11:0] MSG_GAP      = 12'h04B;  // 75 slots between messages.
  localparam logic [11:0] BURST_SPAN   = 12'h20D;  // 525 slots, first to last message.
  localparam logic [11:0] REST_GAP     = 12'h6BD;  // 1725 slots, last to next first.
  localparam logic [11:0] INC_MIN      = 12'h7E9;  // 2025 slots, least reselect step.
  localparam logic [11:0] INC_MAX      = 12'h9AB;  // 2475 slots, largest reselect step.
  localparam logic [11:0] INC_SPAN     = 12'h1C2;  // 450 slots of spread.
  localparam logic [11:0] START_MIN    = 12'h026;  // 38 slots least start delay.
  localparam logic [2:0]  LAST_IDX     = 3'h7;     // Eight messages per burst.
  localparam logic [2:0]  TMO_START    = 3'h7;     // Time-out after a slot change.

  // ----------------------------------------------------------------------------
  // Message field values
  // ----------------------------------------------------------------------------
  localparam logic [5:0]  ID_POS       = 6'h01;
  localparam logic [5:0]  ID_TEXT      = 6'h0E;
  localparam logic [1:0]  REPEAT_NONE  = 2'h0;
  localparam logic [3:0]  NAV_SART     = 4'hE;     // Navigational status 14.
  localparam logic [7:0]  ROT_NA       = 8'h80;    // Rate of turn not available.
  localparam logic [8:0]  HEADING_NA   = 9'h1FF;   // True heading not available.
  localparam logic [5:0]  STAMP_NA     = 6'h3F;    // Time stamp 63.
  localparam logic [9:0]  SOG_NA       = 10'h3FF;
  localparam logic [11:0] COG_NA       = 12'hE10;
  localparam logic [27:0] LON_NA       = 28'h6791AC0;
  localparam logic [26:0] LAT_NA       = 27'h3412140;
  localparam logic [1:0]  SYNC_UTC     = 2'h0;
  localparam logic [1:0]  SYNC_LOST    = 2'h3;
  // Text MOB ACTIVE in six-bit characters, first character in the top bits.
  localparam logic [59:0] TEXT_MOB     = 60'h34F0A0043509585;

  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL     = 8'h00;    // Bit 0 starts the beacon.
  localparam logic [7:0]  REG_SELF_ID  = 8'h04;    // Own identity, 30 bits.
  localparam logic [7:0]  REG_STATUS   = 8'h08;    // Live schedule state.
  localparam logic [7:0]  REG_SLOT     = 8'h0C;    // Current slot number.
  localparam logic [15:0] LFSR_SEED    = 16'hACE1;

endpackage

// File: core/abss_sched.sv
//------------------------------------------------------------------------------
// Purpose: Builds position and text reports and times their eight-message bursts.
// Assumes: Satellite receiver inputs are synchronous to clk.
// Notes:   One report is presented per transmit pulse, fields held until the next.
//------------------------------------------------------------------------------
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module abss_sched
  import abss_pkg::*;
#(
  parameter int unsigned SLOT_CYC_X3_P = SLOT_CYC_X3  // Slot length times three, in cycles.
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  input  wire logic        gnss_valid,
  input  wire logic        utc_pps,
  input  wire logic [5:0]  utc_sec,
  input  wire logic [4:0]  utc_hour,
  input  wire logic [6:0]  utc_min,
  input  wire logic [9:0]  speed_over_ground,
  input  wire logic [11:0] course_over_ground,
  input  wire logic [27:0] pos_lon,
  input  wire logic [26:0] pos_lat,
  input  wire logic        integrity_monitor_used,
  input  wire logic        integrity_monitor_acc,
  output logic             tx_valid,
  output logic             tx_channel,
  output logic [11:0]      tx_slot,
  output logic [5:0]       tx_msg_id,
  output logic [1:0]       tx_repeat,
  output logic [29:0]      tx_self_id,
  output logic [3:0]       tx_nav_status,
  output logic [7:0]       tx_rot,
  output logic [9:0]       tx_sog,
  output logic             tx_pos_acc,
  output logic [27:0]      tx_lon,
  output logic [26:0]      tx_lat,
  output logic [11:0]      tx_cog,
  output logic [8:0]       tx_heading,
  output logic [5:0]       tx_time_stamp,
  output logic             tx_integrity_flag,
  output logic [18:0]      tx_comm_state,
  output logic [59:0]      tx_text
);

  // ----------------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------------
  typedef enum logic {ABSS_OFF, ABSS_RUN} abss_mode_t;

  typedef struct packed {
    abss_mode_t  mode;      // Beacon idle or scheduling.
    logic        start;     // Software start request.
    logic [29:0] self_id;   // Own identity.
    logic [31:0] acc;       // Slot phase accumulator.
    logic [11:0] slot;      // Current slot in the frame.
    logic [15:0] lfsr;      // Random source for slot picks.
    logic [11:0] wait_cnt;  // Slots until the next message.
    logic [2:0]  idx;       // Message position within the burst.
    logic [2:0]  tmo;       // Time-out of the current burst.
    logic [11:0] inc;       // Step to the next slot set.
    logic        tpend;     // A text report is owed.
    logic        tchan;     // Message index, 0 or 1, used for the next text.
    logic [1:0]  bcnt;      // Bursts modulo four.
    logic [9:0]  l_sog;     // Last valid speed.
    logic [11:0] l_cog;     // Last valid course.
    logic [27:0] l_lon;     // Last valid longitude.
    logic [26:0] l_lat;     // Last valid latitude.
    logic [31:0] rdata;     // Read data for one cycle.
    logic        tx_valid;
    logic        tx_channel;
    logic [11:0] tx_slot;
    logic [5:0]  tx_msg_id;
    logic [1:0]  tx_repeat;
    logic [29:0] tx_self_id;
    logic [3:0]  tx_nav_status;
    logic [7:0]  tx_rot;
    logic [9:0]  tx_sog;
    logic        tx_pos_acc;
    logic [27:0] tx_lon;
    logic [26:0] tx_lat;
    logic [11:0] tx_cog;
    logic [8:0]  tx_heading;
    logic [5:0]  tx_time_stamp;
    logic        tx_flag;
    logic [18:0] tx_comm;
    logic [59:0] tx_text;
  } abss_state_t;

  abss_state_t st;       // Registered state.
  abss_state_t next_st;  // Next state.

  // Slot tick and the helpers that the next-state logic shares.
  logic        tick;      // One cycle per slot boundary.
  logic        fire;      // A message goes out this cycle.
  logic        is_text;   // This message becomes the text report.
  logic [13:0] sub_msg;   // Communication sub-message.
  logic [11:0] pick;      // Fresh reselect step spread.

  assign tick = (st.acc >= SLOT_CYC_X3_P - 32'd3);
  assign fire = (st.mode == ABSS_RUN) && tick && (st.wait_cnt == 12'h001);
  assign is_text = st.tpend && (st.tmo != 3'h0) && (st.idx == {2'b00, st.tchan});
  assign pick = (st.lfsr[8:0] > INC_SPAN[8:0]) ? {4'h0, st.lfsr[7:0]}
                                               : {3'h0, st.lfsr[8:0]};

  // ----------------------------------------------------------------------------
  // Communication sub-message by time-out
  // ----------------------------------------------------------------------------
  // Chooses what the report announces from the current time-out value.
  always_comb begin
    unique case (st.tmo)
      3'h3, 3'h5, 3'h7: sub_msg = 14'h0000;
      3'h2, 3'h4, 3'h6: sub_msg = {2'b00, st.slot};
      3'h1:             sub_msg = {utc_hour, utc_min, 2'b00};
      3'h0:             sub_msg = {2'b00, st.inc};
    endcase
  end

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  // Runs the slot clock, the burst schedule, the report builder and the registers.
  always_comb begin
    next_st = st;
    next_st.tx_valid = 1'b0;
    next_st.rdata = 32'h0000_0000;
    next_st.lfsr = {st.lfsr[14:0], st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10]};
    // Slot phase advances by three each cycle; whole slots roll into the frame count.
    if (tick) begin
      next_st.acc = st.acc + 32'd3 - SLOT_CYC_X3_P;
      next_st.slot = (st.slot == FRAME_SLOTS - 12'h001) ? 12'h000 : st.slot + 12'h001;
    end else begin
      next_st.acc = st.acc + 32'd3;
    end
    // An even UTC second starts exactly on a slot boundary, so realign there.
    if (utc_pps && gnss_valid && !utc_sec[0]) begin
      next_st.acc = 32'h0000_0000;
      next_st.slot = 12'(utc_sec[5:1]) * MSG_GAP;
    end
    // Keep the last valid fix for use once positioning is lost.
    if (gnss_valid) begin
      next_st.l_sog = speed_over_ground;
      next_st.l_cog = course_over_ground;
      next_st.l_lon = pos_lon;
      next_st.l_lat = pos_lat;
    end
    // Register writes.
    if (wr) begin
      if (addr == REG_CTRL) begin
        next_st.start = wdata[0];
      end else if (addr == REG_SELF_ID) begin
        next_st.self_id = wdata[29:0];
      end
    end
    // Register reads; unmapped addresses read zero.
    if (rd) begin
      unique case (addr)
        REG_CTRL:    next_st.rdata = {31'h0, st.start};
        REG_SELF_ID: next_st.rdata = {2'b00, st.self_id};
        REG_STATUS:  next_st.rdata = {16'h0, st.bcnt, st.tpend, st.tchan, gnss_valid,
                                      st.idx, st.tmo, 4'h0, st.mode == ABSS_RUN};
        REG_SLOT:    next_st.rdata = {20'h0, st.slot};
        default:     next_st.rdata = 32'h0000_0000;
      endcase
    end
    unique case (st.mode)
      // Idle: on start, place the first message within a few seconds.
      ABSS_OFF: begin
        if (st.start) begin
          next_st.mode = ABSS_RUN;
          next_st.wait_cnt = START_MIN + {4'h0, st.lfsr[7:0]};
          next_st.idx = 3'h0;
          next_st.tmo = TMO_START;
          next_st.inc = FRAME_SLOTS;
          next_st.tpend = 1'b1;
          next_st.tchan = 1'b0;
          next_st.bcnt = 2'h0;
        end
      end
      // Running: count slots down to each message of the burst.
      ABSS_RUN: begin
        if (!st.start) begin
          next_st.mode = ABSS_OFF;
        end else if (tick) begin
          next_st.wait_cnt = st.wait_cnt - 12'h001;
          if (fire) begin
            next_st.tx_valid = 1'b1;
            next_st.tx_channel = st.idx[0];
            next_st.tx_slot = st.slot;
            next_st.tx_repeat = REPEAT_NONE;
            next_st.tx_self_id = st.self_id;
            next_st.tx_nav_status = NAV_SART;
            next_st.tx_rot = ROT_NA;
            next_st.tx_heading = HEADING_NA;
            next_st.tx_text = TEXT_MOB;
            // Sync state tells whether slot timing comes straight from UTC.
            next_st.tx_comm = {gnss_valid ? SYNC_UTC : SYNC_LOST, st.tmo, sub_msg};
            if (is_text) begin
              next_st.tx_msg_id = ID_TEXT;
              next_st.tpend = 1'b0;
              next_st.tchan = ~st.tchan;
            end else begin
              next_st.tx_msg_id = ID_POS;
            end
            // Fix is sampled per message while positioning is valid; otherwise the last valid fix is sent.
            if (gnss_valid) begin
              next_st.tx_sog = speed_over_ground;
              next_st.tx_cog = course_over_ground;
              next_st.tx_lon = pos_lon;
              next_st.tx_lat = pos_lat;
              next_st.tx_pos_acc = integrity_monitor_used & integrity_monitor_acc;
              next_st.tx_flag = integrity_monitor_used;
              next_st.tx_time_stamp = utc_sec;
            end else begin
              next_st.tx_sog = st.l_sog;
              next_st.tx_cog = st.l_cog;
              next_st.tx_lon = st.l_lon;
              next_st.tx_lat = st.l_lat;
              next_st.tx_pos_acc = 1'b0;
              next_st.tx_flag = 1'b0;
              next_st.tx_time_stamp = STAMP_NA;
            end
            if (st.idx != LAST_IDX) begin
              next_st.idx = st.idx + 3'h1;
              next_st.wait_cnt = MSG_GAP;
            end else begin
              // Burst done: next one a frame later, or one step later on reselect.
              next_st.idx = 3'h0;
              next_st.bcnt = st.bcnt + 2'h1;
              if (st.bcnt == 2'h3) begin
                next_st.tpend = 1'b1;
              end
              if (st.tmo == 3'h0) begin
                next_st.wait_cnt = st.inc - BURST_SPAN;
                next_st.tmo = TMO_START;
              end else begin
                next_st.wait_cnt = REST_GAP;
                next_st.tmo = st.tmo - 3'h1;
              end
              // The step is drawn one burst early so time-out 0 can announce it.
              if (st.tmo == 3'h1) begin
                next_st.inc = INC_MIN + pick;
              end
            end
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  // Holds the whole record; reset leaves the beacon idle with the held fix not available.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.mode <= ABSS_OFF;
      st.lfsr <= LFSR_SEED;
      st.tmo <= TMO_START;
      st.inc <= FRAME_SLOTS;
      st.l_sog <= SOG_NA;
      st.l_cog <= COG_NA;
      st.l_lon <= LON_NA;
      st.l_lat <= LAT_NA;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state record.
  assign rdata = st.rdata;
  assign tx_valid = st.tx_valid;
  assign tx_channel = st.tx_channel;
  assign tx_slot = st.tx_slot;
  assign tx_msg_id = st.tx_msg_id;
  assign tx_repeat = st.tx_repeat;
  assign tx_self_id = st.tx_self_id;
  assign tx_nav_status = st.tx_nav_status;
  assign tx_rot = st.tx_rot;
  assign tx_sog = st.tx_sog;
  assign tx_pos_acc = st.tx_pos_acc;
  assign tx_lon = st.tx_lon;
  assign tx_lat = st.tx_lat;
  assign tx_cog = st.tx_cog;
  assign tx_heading = st.tx_heading;
  assign tx_time_stamp = st.tx_time_stamp;
  assign tx_integrity_flag = st.tx_flag;
  assign tx_comm_state = st.tx_comm;
  assign tx_text = st.tx_text;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  logic [11:0] gap;       // Slots since the last message.
  logic        prev_ch;   // Channel of the last message.
  logic        seen;      // At least one message has gone out.

  // Tracks spacing between messages for the checks below.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap <= 12'h000;
      prev_ch <= 1'b0;
      seen <= 1'b0;
    end else if (fire) begin
      gap <= 12'h001;
      prev_ch <= st.idx[0];
      seen <= 1'b1;
    end else if (tick && gap != 12'hFFF) begin
      gap <= gap + 12'h001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_no_rot_heading: assert property (tx_valid |-> tx_rot == ROT_NA && tx_heading == HEADING_NA)
    else $error("rate of turn or heading not default");
  a_pos_header: assert property (tx_valid && tx_msg_id == ID_POS |->
      tx_repeat == 2'h0 && tx_nav_status == NAV_SART && tx_self_id == st.self_id)
    else $error("position report header wrong");
  a_text_body: assert property (tx_valid && tx_msg_id == ID_TEXT |->
      tx_text == TEXT_MOB && tx_repeat == 2'h0)
    else $error("text report body wrong");
  a_msg_spacing: assert property (fire && seen && st.idx != 3'h0 |-> gap == MSG_GAP)
    else $error("burst messages not 75 slots apart");
  a_chan_alt: assert property (fire && seen && st.idx != 3'h0 |=> tx_channel != $past(prev_ch))
    else $error("channels do not alternate");
  a_lost_fields: assert property (tx_valid && tx_comm_state[18:17] == SYNC_LOST |->
      tx_time_stamp == STAMP_NA && !tx_integrity_flag && !tx_pos_acc)
    else $error("lost positioning fields wrong");
  a_stamp_range: assert property (tx_valid && tx_comm_state[18:17] == SYNC_UTC |->
      tx_time_stamp <= 6'd59)
    else $error("time stamp out of range");
  a_step_range: assert property (st.inc >= INC_MIN && st.inc <= INC_MAX || st.inc == FRAME_SLOTS)
    else $error("reselect step out of range");
  a_text_tmo: assert property (tx_valid && tx_msg_id == ID_TEXT |-> tx_comm_state[16:14] != 3'h0)
    else $error("text replaced a time-out 0 report");
  a_sync_state: assert property (fire |=> tx_comm_state[18:17] == ($past(gnss_valid) ? 2'h0 : 2'h3))
    else $error("sync state wrong");

endmodule

// File: testbench/abss_radio_model.sv
// Purpose: Radio transmitter stand-in that takes each presented report.
// Assumes: One report per tx_valid pulse, fields held until the next one.
// Notes:   Tallies reports in total and on the second channel.
`timescale 1ns/1ps
module abss_radio_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        tx_valid,
  input  wire logic        tx_channel,
  output logic [15:0]      msg_count,
  output logic [15:0]      ch1_count
);
  // Counts every report sent on air, and those sent on the second channel.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      msg_count <= 16'h0000;
      ch1_count <= 16'h0000;
    end else if (tx_valid) begin
      msg_count <= msg_count + 16'h0001;
      ch1_count <= ch1_count + {15'h0000, tx_channel};
    end
  end
endmodule

// File: testbench/ais_burst_slot_scheduler_tb.sv
// Purpose: Self-checking bench for the burst slot scheduler.
// Assumes: Slots shortened to 2 cycles, one second is 75 cycles.
// Notes:   Ten bursts are run through one slot reselection; the last one without positioning.
`timescale 1ns/1ps
module ais_burst_slot_scheduler_tb;
  import abss_pkg::*;
  logic clk = 0, arst_n = 0, wr = 0, rd = 0, utc_pps = 0, gnss_valid = 1;
  logic integrity_monitor_used = 0, integrity_monitor_acc = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rng = 32'h35, r;
  logic [5:0] utc_sec = 6'h00, sec_d, tx_msg_id, tx_time_stamp;
  logic [9:0] speed_over_ground = 10'h000, tx_sog;
  logic [11:0] course_over_ground = 12'h000, tx_slot, tx_cog;
  logic [27:0] pos_lon = 28'h0, tx_lon;
  logic [26:0] pos_lat = 27'h0, tx_lat;
  logic tx_valid, tx_channel, tx_pos_acc, tx_integrity_flag, gnss_d;
  logic [1:0] tx_repeat;
  logic [29:0] tx_self_id, self_id;
  logic [3:0] tx_nav_status;
  logic [7:0] tx_rot;
  logic [8:0] tx_heading;
  logic [18:0] tx_comm_state;
  logic [59:0] tx_text;
  logic [15:0] msg_count, ch1_count;
  logic [78:0] lv;  // Last fix seen while positioning was valid.
  logic [4:0] utc_hour = 5'h0C;  // Held hour; the minute below advances each UTC minute.
  logic [6:0] utc_min = 7'h1E;
  logic [11:0] hm_d;  // Hour and minute as the design saw them at a report.
  localparam int SEC_CYC = 75;  // Cycles per UTC second with 2-cycle slots.
  int err_total = 0, check_count = 0, n = 0, ph = 0, k, b, es, first_slot, txt_cnt = 0;
  int tmo, inc = 0, exp_sub, txt_exp;
  longint t0;

  abss_sched #(.SLOT_CYC_X3_P(6)) abss_sched_inst (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gnss_valid(gnss_valid), .utc_pps(utc_pps),
    .utc_sec(utc_sec), .utc_hour(utc_hour), .utc_min(utc_min),
    .speed_over_ground(speed_over_ground), .course_over_ground(course_over_ground),
    .pos_lon(pos_lon), .pos_lat(pos_lat),
    .integrity_monitor_used(integrity_monitor_used), .integrity_monitor_acc(integrity_monitor_acc),
    .tx_valid(tx_valid), .tx_channel(tx_channel), .tx_slot(tx_slot), .tx_msg_id(tx_msg_id),
    .tx_repeat(tx_repeat), .tx_self_id(tx_self_id), .tx_nav_status(tx_nav_status), .tx_rot(tx_rot),
    .tx_sog(tx_sog), .tx_pos_acc(tx_pos_acc), .tx_lon(tx_lon), .tx_lat(tx_lat), .tx_cog(tx_cog),
    .tx_heading(tx_heading), .tx_time_stamp(tx_time_stamp),
    .tx_integrity_flag(tx_integrity_flag), .tx_comm_state(tx_comm_state), .tx_text(tx_text));
  abss_radio_model abss_radio_model_inst (.clk(clk), .arst_n(arst_n), .tx_valid(tx_valid),
    .tx_channel(tx_channel), .msg_count(msg_count), .ch1_count(ch1_count));

  // Free-running 100 MHz clock.
  initial forever #5 clk = ~clk;

  // Pseudo-random source for identity and fix values.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // Compares one value and reports a difference.
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Prints the verdict and stops the run.
  task automatic conclude();
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Register write and read cycles; read data is taken in the cycle after the strobe.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(posedge clk) d = rdata;
  endtask

  // Second pulses every 75 cycles, each bringing a fresh random fix.
  always @(posedge clk) begin
    ph <= (ph == SEC_CYC - 1) ? 0 : ph + 1;
    utc_pps <= (ph == SEC_CYC - 1);
    if (ph == SEC_CYC - 1) begin
      rng = xs(rng);
      utc_sec <= (utc_sec == 6'h3B) ? 6'h00 : utc_sec + 6'h01;
      if (utc_sec == 6'h3B) utc_min <= (utc_min == 7'h3B) ? 7'h00 : utc_min + 7'h01;
      {integrity_monitor_used, integrity_monitor_acc, speed_over_ground, course_over_ground} <=
        rng[23:0];
      pos_lon <= rng[27:0];
      pos_lat <= rng[31:5];
    end
  end

  // Reference model: inputs as the design saw them when it latched a report.
  always @(posedge clk) begin
    sec_d <= utc_sec;
    gnss_d <= gnss_valid;
    hm_d <= {utc_hour, utc_min};
    if (gnss_valid) lv <= {integrity_monitor_used, integrity_monitor_acc, speed_over_ground,
      course_over_ground, pos_lon, pos_lat};
    if (tx_valid === 1'b1) begin
      k = n % 8;
      b = n / 8;
      tmo = 7 - b % 8;
      // Text every fourth burst, on message 0 and 1 in turn.
      txt_exp = (b % 4 == 0) && (k == (b / 4) % 2);
      // After a time-out 0 burst the set moves by the step that burst announced.
      if (n == 0) first_slot = tx_slot;
      else if (k == 0 && tmo == 7) first_slot = (first_slot + inc) % 2250;
      if (n == 0) chk("first_delay", ($time - t0) <= 45000, 1);
      if (k == 0 && tmo == 0) inc = tx_comm_state[13:0];
      es = (first_slot + 75 * k) % 2250;
      exp_sub = (tmo == 0) ? inc : (tmo == 1) ? {hm_d, 2'b00} : (tmo % 2 == 1) ? 0 : es;
      chk("slot", tx_slot, es);
      chk("channel", tx_channel, k % 2);
      chk("timeout", tx_comm_state[16:14], tmo);
      chk("sync", tx_comm_state[18:17], gnss_d ? 0 : 3);
      chk("sub_msg", tx_comm_state[13:0], exp_sub);
      if (tmo == 0) chk("step_range", inc >= 2025 && inc <= 2475, 1);
      chk("repeat_self", {tx_repeat, tx_self_id}, {2'h0, self_id});
      chk("msg_id", tx_msg_id, txt_exp ? ID_TEXT : ID_POS);
      if (tx_msg_id === ID_TEXT) begin
        txt_cnt++;
        chk("text_place", txt_exp, 1);
        chk("text", tx_text, TEXT_MOB);
      end else begin
        chk("fixed", {tx_nav_status, tx_rot, tx_heading}, {NAV_SART, ROT_NA, HEADING_NA});
        chk("sog_cog", {tx_sog, tx_cog}, lv[76:55]);
        chk("position", {tx_lon, tx_lat}, lv[54:0]);
        chk("acc_flag", {tx_pos_acc, tx_integrity_flag},
          {gnss_d & lv[78] & lv[77], gnss_d & lv[78]});
        chk("stamp", tx_time_stamp, gnss_d ? sec_d : STAMP_NA);
      end
      n++;
    end
  end

  // Main sequence: registers, start, nine bursts with a fix, one without.
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    self_id = xs(32'h35) >> 2;
    wr_reg(REG_SELF_ID, {2'h0, self_id});
    rd_reg(REG_SELF_ID, r);
    chk("self_id_reg", r, {2'h0, self_id});
    rd_reg(8'h10, r);
    chk("unmapped", r, 0);
    @(posedge clk) chk("rdata_idle", rdata, 0);
    wr_reg(REG_CTRL, 32'h1);
    t0 = $time;
    wait (msg_count == 16'h0048);
    @(posedge clk) gnss_valid <= 1'b0;
    wait (msg_count == 16'h0050);
    repeat (2) @(posedge clk);
    chk("text_count", txt_cnt, 3);
    chk("ais2_count", ch1_count, 40);
    conclude();
  end

  // Ten bursts take about 42k cycles; allow 80k before calling it a hang.
  initial begin
    #800000;
    err_total++;
    conclude();
  end
endmodule
